// >>> verif/srwrp_monitor.sv
`timescale 1ns/10ps
module srwrp_monitor import srwrp_pkg::*; (
  // system
  input wire logic sys_clk,
  input wire logic rst,
  // link
  input wire logic sck,
  input wire logic serial_data_in,
  input wire logic chip_select_n,
  input wire logic multiplexed_readback_out
);
  logic       sck_q;
  logic       sck_d;
  logic [4:0] rises_q;
  logic [4:0] rises_d;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // rising link clock edges seen in the current frame
  always_comb begin
    sck_d   = sck;
    rises_d = rises_q;
    if (chip_select_n) begin
      rises_d = 5'h00;
    end else if (sck && !sck_q) begin
      rises_d = rises_q + 5'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sck_q   <= 1'b0;
      rises_q <= 5'h00;
    end else begin
      sck_q   <= sck_d;
      rises_q <= rises_d;
    end
  end

  AST_CS_FALL_SCK_LOW: assert property ($fell(chip_select_n) |-> !sck)
    else $error("select fell with clock high");
  AST_SCK_STILL_IDLE: assert property (chip_select_n |-> !sck)
    else $error("clock moved outside a frame");
  AST_SDI_STABLE_HIGH: assert property (sck |-> $stable(serial_data_in))
    else $error("data changed while clock high");
  AST_RB_LOW_IDLE: assert property (chip_select_n |-> !multiplexed_readback_out)
    else $error("readback driven while deselected");
  AST_RB_LOW_HDR: assert property (!chip_select_n && rises_q < 5'h08 |-> !multiplexed_readback_out)
    else $error("readback driven during header");
  AST_FRAME_BITS: assert property ($rose(chip_select_n) |-> rises_q == 5'(FRAME_BITS))
    else $error("frame length wrong");
  AST_SCK_HIGH_SPAN: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
    else $error("clock high phase wrong");
  AST_CS_GAP: assert property ($rose(chip_select_n) |-> chip_select_n [*4])
    else $error("select high gap too short");
endmodule : srwrp_monitor

// >>> verif/srwrp_tb.sv
`timescale 1ns/10ps
module srwrp_tb import srwrp_pkg::*;;
  logic        sys_clk, rst, req_valid, req_write, req_ready_q, resp_valid_q, b_pulse, a_pulse;
  int          a_commits;
  logic [6:0]  req_addr, cfg_rd_addr;
  logic [15:0] req_data, resp_data_q, rd_data, wr_data, b_rd;
  logic [6:0]  wr_addr;
  int          num_errors, comparisons, b_commits;
  logic [6:0]  t_addr [3] = '{7'h00, 7'h7F, 7'h2A};
  logic [15:0] t_data [3] = '{16'hA5C3, 16'hFFFF, 16'h0001};

  srwrp_if link ();
  srwrp_if link_b ();
  srwrp_host u_srwrp_host (.link(link), .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_data(req_data), .req_ready_q(req_ready_q),
    .resp_valid_q(resp_valid_q), .resp_data_q(resp_data_q));
  srwrp_dev u_srwrp_dev (.link(link), .sys_clk(sys_clk), .rst(rst), .cfg_rd_addr(cfg_rd_addr),
    .cfg_rd_data_q(rd_data), .cfg_wr_pulse_q(a_pulse), .cfg_wr_addr_q(wr_addr), .cfg_wr_data_q(wr_data));
  // second device driven straight by the bench to break the host's side on purpose
  srwrp_dev u_srwrp_dev_b (.link(link_b), .sys_clk(sys_clk), .rst(rst), .cfg_rd_addr(7'h05),
    .cfg_rd_data_q(b_rd), .cfg_wr_pulse_q(b_pulse), .cfg_wr_addr_q(), .cfg_wr_data_q());
  srwrp_monitor u_srwrp_monitor (.sys_clk(sys_clk), .rst(rst), .sck(link.sck),
    .serial_data_in(link.serial_data_in), .chip_select_n(link.chip_select_n),
    .multiplexed_readback_out(link.multiplexed_readback_out));

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (b_pulse === 1'b1) b_commits++;
  always @(posedge sys_clk) if (a_pulse === 1'b1) a_commits++;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic xfer(input logic wr, input logic [6:0] a, input logic [15:0] d, input logic [15:0] exp);
    int n;
    req_write <= wr;
    req_addr  <= a;
    req_data  <= d;
    req_valid <= 1'b1;
    do @(posedge sys_clk); while (req_ready_q !== 1'b1);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (resp_valid_q !== 1'b1 && n < 300);
    check(16'(n >= 190 && n <= 205), 16'h0001);
    check(resp_data_q, exp);
  endtask : xfer

  task automatic peek(input logic [6:0] a, input logic [15:0] exp);
    repeat (6) @(posedge sys_clk);
    cfg_rd_addr <= a;
    repeat (2) @(posedge sys_clk);
    check(rd_data, exp);
  endtask : peek

  task automatic bb_frame(input logic sel, input int nb, input logic [23:0] f);
    link_b.chip_select_n <= !sel;
    #32;
    for (int i = 23; i > 23 - nb; i--) begin
      link_b.serial_data_in <= f[i];
      #32 link_b.sck <= 1'b1;
      #32 link_b.sck <= 1'b0;
    end
    link_b.serial_data_in <= ~link_b.serial_data_in;
    #32 link_b.chip_select_n <= 1'b1;
    #200;
  endtask : bb_frame

  initial begin
    #100000;
    num_errors++;
    $display("watchdog expired");
    test_done();
  end

  initial begin
    {sys_clk, req_valid, req_write, req_addr, req_data, cfg_rd_addr} = '0;
    {link_b.sck, link_b.serial_data_in, link_b.chip_select_n} = 3'h1;
    rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    xfer(1'b0, 7'h7F, 16'h0000, 16'h0000);
    peek(7'h7F, 16'h0000);
    $display("test reset readback done");
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, t_addr[i], t_data[i], 16'h0000);
      peek(t_addr[i], t_data[i]);
      check({9'h000, wr_addr}, {9'h000, t_addr[i]});
      check(wr_data, t_data[i]);
    end
    check(16'(a_commits), 16'h0003);
    $display("test writes done");
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, t_addr[i], ~t_data[i], t_data[i]);
      peek(t_addr[i], t_data[i]);
    end
    check(16'(a_commits), 16'h0003);
    $display("test readbacks done");
    bb_frame(1'b0, 24, {RW_WRITE, 7'h05, 16'h1234});
    bb_frame(1'b1, 10, {RW_WRITE, 7'h05, 16'h1234});
    check(16'(b_commits), 16'h0000);
    check(b_rd, 16'h0000);
    bb_frame(1'b1, 24, {RW_WRITE, 7'h05, 16'h1234});
    repeat (6) @(posedge sys_clk);
    check(16'(b_commits), 16'h0001);
    check(b_rd, 16'h1234);
    $display("test select faults done");
    test_done();
  end
endmodule : srwrp_tb

// >>> verilog/srwrp_dev.sv
`timescale 1ns/10ps
module srwrp_dev import srwrp_pkg::*; (
  // serial link
  srwrp_if.dev                      link,
  // system
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // register view
  input  wire logic [ADDR_BITS-1:0] cfg_rd_addr,
  output logic      [DATA_BITS-1:0] cfg_rd_data_q,
  // commit notification
  output logic                      cfg_wr_pulse_q,
  output logic      [ADDR_BITS-1:0] cfg_wr_addr_q,
  output logic      [DATA_BITS-1:0] cfg_wr_data_q
);

  // ---------------- link domain (sck) ----------------
  logic                  frame_rst;
  logic                  bit_take;
  logic [CNT_W-1:0]      cnt_q,   cnt_d;
  logic [FRAME_BITS-1:0] shift_q, shift_d;
  logic [HDR_BITS-1:0]   hdr_q,   hdr_d;
  logic                  tgl_q,   tgl_d;
  logic                  rb_q,    rb_d;
  logic [3:0]            rb_idx;
  logic [DATA_BITS-1:0]  regs_q [REG_COUNT];

  // select high holds the bit counter at zero whatever the clock does
  assign frame_rst = rst | link.chip_select_n;

  // a bit is taken only inside a frame and only up to the frame length
  assign bit_take = !link.chip_select_n && (cnt_q < CNT_W'(FRAME_BITS));

  always_comb begin
    cnt_d = cnt_q;
    if (bit_take) begin
      cnt_d = cnt_q + 5'h01;
    end
  end

  // select high clears the count at once, whatever the clock does
  always_ff @(posedge link.sck or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_comb begin
    shift_d = shift_q;
    hdr_d   = hdr_q;
    tgl_d   = tgl_q;
    if (bit_take) begin
      shift_d = {shift_q[FRAME_BITS-2:0], link.serial_data_in};
      if (cnt_q == CNT_W'(HDR_BITS - 1)) begin
        hdr_d = shift_d[HDR_BITS-1:0];
      end
      if (cnt_q == CNT_W'(FRAME_BITS - 1) && hdr_q[HDR_BITS-1] == RW_WRITE) begin
        tgl_d = ~tgl_q;
      end
    end
  end

  always_ff @(posedge link.sck or posedge rst) begin
    if (rst) begin
      shift_q <= '0;
      hdr_q   <= '0;
      tgl_q   <= 1'h0;
    end else begin
      shift_q <= shift_d;
      hdr_q   <= hdr_d;
      tgl_q   <= tgl_d;
    end
  end

  // read bits change on the falling edge so they are steady at the next rise;
  // the register array only changes after select rises, so it is quiet here
  assign rb_idx = 4'(CNT_W'(FRAME_BITS - 1) - cnt_q);

  always_comb begin
    rb_d = 1'h0;
    if (cnt_q >= CNT_W'(HDR_BITS) && cnt_q < CNT_W'(FRAME_BITS) &&
        hdr_q[HDR_BITS-1] == RW_READ) begin
      rb_d = regs_q[hdr_q[ADDR_BITS-1:0]][rb_idx];
    end
  end

  always_ff @(negedge link.sck or posedge frame_rst) begin
    if (frame_rst) begin
      rb_q <= 1'h0;
    end else begin
      rb_q <= rb_d;
    end
  end

  assign link.multiplexed_readback_out = rb_q;

  // ---------------- system domain (sys_clk) ----------------
  logic                 cs_s1_q, cs_s2_q, cs_s3_q;
  logic                 cs_s1_d, cs_s2_d, cs_s3_d;
  logic                 tg_s1_q, tg_s2_q, tg_s3_q;
  logic                 tg_s1_d, tg_s2_d, tg_s3_d;
  logic                 pend_q,  pend_d;
  logic                 commit;
  logic                 wr_pulse_d;
  logic [ADDR_BITS-1:0] wr_addr_d;
  logic [DATA_BITS-1:0] wr_data_d;
  logic [DATA_BITS-1:0] rd_data_d;

  // select and the write toggle cross from the link clock through two flops;
  // the third flop of each chain only serves edge detection
  always_comb begin
    cs_s1_d = link.chip_select_n;
    cs_s2_d = cs_s1_q;
    cs_s3_d = cs_s2_q;
    tg_s1_d = tgl_q;
    tg_s2_d = tg_s1_q;
    tg_s3_d = tg_s2_q;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cs_s1_q <= 1'h1;
      cs_s2_q <= 1'h1;
      cs_s3_q <= 1'h1;
      tg_s1_q <= 1'h0;
      tg_s2_q <= 1'h0;
      tg_s3_q <= 1'h0;
    end else begin
      cs_s1_q <= cs_s1_d;
      cs_s2_q <= cs_s2_d;
      cs_s3_q <= cs_s3_d;
      tg_s1_q <= tg_s1_d;
      tg_s2_q <= tg_s2_d;
      tg_s3_q <= tg_s3_d;
    end
  end

  // a finished write frame stays pending until select is seen high again
  always_comb begin
    pend_d = pend_q | (tg_s2_q ^ tg_s3_q);
    commit = cs_s2_q & ~cs_s3_q & pend_d;
    if (commit) begin
      pend_d = 1'h0;
    end
    wr_pulse_d = commit;
    wr_addr_d  = cfg_wr_addr_q;
    wr_data_d  = cfg_wr_data_q;
    if (commit) begin
      // frame word is static: no more bits shift until the next frame
      wr_addr_d = shift_q[RW_POS-1 -: ADDR_BITS];
      wr_data_d = shift_q[DATA_BITS-1:0];
    end
  end

  // commit notification towards the user side
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_q         <= 1'h0;
      cfg_wr_pulse_q <= 1'h0;
      cfg_wr_addr_q  <= '0;
      cfg_wr_data_q  <= '0;
    end else begin
      pend_q         <= pend_d;
      cfg_wr_pulse_q <= wr_pulse_d;
      cfg_wr_addr_q  <= wr_addr_d;
      cfg_wr_data_q  <= wr_data_d;
    end
  end

  // one storage word per register entry, loaded only by a committed write
  for (genvar e = 0; e < REG_COUNT; e++) begin : g_reg
    logic [DATA_BITS-1:0] word_d;

    always_comb begin
      word_d = regs_q[e];
      if (commit && (wr_addr_d == ADDR_BITS'(e))) begin
        word_d = wr_data_d;
      end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        regs_q[e] <= REG_RESET;
      end else begin
        regs_q[e] <= word_d;
      end
    end
  end : g_reg

  // user read port: data follows the address one cycle later
  always_comb begin
    rd_data_d = regs_q[cfg_rd_addr];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfg_rd_data_q <= '0;
    end else begin
      cfg_rd_data_q <= rd_data_d;
    end
  end

endmodule : srwrp_dev

// >>> verilog/srwrp_host.sv
`timescale 1ns/10ps
module srwrp_host import srwrp_pkg::*; (
  // serial link
  srwrp_if.host                     link,
  // system
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // request
  input  wire logic                 req_valid,
  input  wire logic                 req_write,
  input  wire logic [ADDR_BITS-1:0] req_addr,
  input  wire logic [DATA_BITS-1:0] req_data,
  output logic                      req_ready_q,
  // response
  output logic                      resp_valid_q,
  output logic      [DATA_BITS-1:0] resp_data_q
);

  srwrp_hst_e            st_q,    st_d;
  logic [TMR_W-1:0]      tmr_q,   tmr_d;
  logic [CNT_W-1:0]      bit_q,   bit_d;
  logic [FRAME_BITS-1:0] tx_q,    tx_d;
  logic [DATA_BITS-1:0]  rx_q,    rx_d;
  logic                  wr_q,    wr_d;
  logic                  sck_q,   sck_d;
  logic                  sdo_q,   sdo_d;
  logic                  csn_q,   csn_d;
  logic                  rdy_d;
  logic                  rv_d;
  logic [DATA_BITS-1:0]  rdat_d;
  logic                  rb_s1_q, rb_s2_q;
  logic                  tmr_end;

  assign tmr_end = (tmr_q == TMR_W'(SCK_HALF_CYC - 1));

  always_comb begin
    st_d   = st_q;
    tmr_d  = tmr_end ? '0 : tmr_q + 3'h1;
    bit_d  = bit_q;
    tx_d   = tx_q;
    rx_d   = rx_q;
    wr_d   = wr_q;
    sck_d  = sck_q;
    sdo_d  = sdo_q;
    csn_d  = csn_q;
    rv_d   = 1'h0;
    rdat_d = resp_data_q;
    case (st_q)
      HST_IDLE: begin
        tmr_d = '0;
        csn_d = 1'h1;
        if (req_valid) begin
          wr_d  = req_write;
          tx_d  = {(req_write ? RW_WRITE : RW_READ), req_addr,
                   (req_write ? req_data : '0)};
          sdo_d = tx_d[RW_POS];
          bit_d = '0;
          sck_d = 1'h0;
          csn_d = 1'h0;
          st_d  = HST_LOW;
        end
      end
      HST_LOW: begin
        if (tmr_end) begin
          sck_d = 1'h1;
          rx_d  = {rx_q[DATA_BITS-2:0], rb_s2_q};
          st_d  = HST_HIGH;
        end
      end
      HST_HIGH: begin
        if (tmr_end) begin
          sck_d = 1'h0;
          if (bit_q == CNT_W'(FRAME_BITS - 1)) begin
            st_d = HST_TRAIL;
          end else begin
            bit_d = bit_q + 5'h01;
            tx_d  = {tx_q[FRAME_BITS-2:0], 1'h0};
            sdo_d = tx_d[RW_POS];
            st_d  = HST_LOW;
          end
        end
      end
      HST_TRAIL: begin
        if (tmr_end) begin
          csn_d = 1'h1;
          st_d  = HST_GAP;
        end
      end
      HST_GAP: begin
        if (tmr_end) begin
          rv_d   = 1'h1;
          rdat_d = wr_q ? '0 : rx_q;
          st_d   = HST_IDLE;
        end
      end
      default: begin
        csn_d = 1'h1;
        sck_d = 1'h0;
        st_d  = HST_IDLE;
      end
    endcase
    rdy_d = (st_d == HST_IDLE) && !(st_q == HST_IDLE && req_valid);
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q         <= HST_IDLE;
      tmr_q        <= '0;
      bit_q        <= '0;
      tx_q         <= '0;
      rx_q         <= '0;
      wr_q         <= 1'h0;
      sck_q        <= 1'h0;
      sdo_q        <= 1'h0;
      csn_q        <= 1'h1;
      req_ready_q  <= 1'h0;
      resp_valid_q <= 1'h0;
      resp_data_q  <= '0;
      rb_s1_q      <= 1'h0;
      rb_s2_q      <= 1'h0;
    end else begin
      st_q         <= st_d;
      tmr_q        <= tmr_d;
      bit_q        <= bit_d;
      tx_q         <= tx_d;
      rx_q         <= rx_d;
      wr_q         <= wr_d;
      sck_q        <= sck_d;
      sdo_q        <= sdo_d;
      csn_q        <= csn_d;
      req_ready_q  <= rdy_d;
      resp_valid_q <= rv_d;
      resp_data_q  <= rdat_d;
      rb_s1_q      <= link.multiplexed_readback_out;
      rb_s2_q      <= rb_s1_q;
    end
  end

  assign link.sck            = sck_q;
  assign link.serial_data_in = sdo_q;
  assign link.chip_select_n  = csn_q;

endmodule : srwrp_host

// >>> verilog/srwrp_if.sv
`timescale 1ns/10ps
interface srwrp_if;
  logic sck;
  logic serial_data_in;
  logic chip_select_n;
  logic multiplexed_readback_out;

  modport dev (
    input  sck,
    input  serial_data_in,
    input  chip_select_n,
    output multiplexed_readback_out
  );

  modport host (
    output sck,
    output serial_data_in,
    output chip_select_n,
    input  multiplexed_readback_out
  );
endinterface : srwrp_if

// >>> verilog/srwrp_pkg.sv
package srwrp_pkg;
  localparam int          FRAME_BITS     = 24;
  localparam int          HDR_BITS       = 8;
  localparam int          ADDR_BITS      = 7;
  localparam int          DATA_BITS      = 16;
  localparam int          REG_COUNT      = 128;
  localparam int          CNT_W          = 5;
  localparam int          RW_POS         = 23;
  localparam logic        RW_WRITE       = 1'h0;
  localparam logic        RW_READ        = 1'h1;
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam int          SYS_CLK_NS     = 10;
  localparam int          SCK_HALF_NS    = 40;
  localparam int          SCK_HALF_CYC   = (SCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int          TMR_W          = 3;

  typedef enum logic [2:0] {
    HST_IDLE  = 3'h0,
    HST_LOW   = 3'h1,
    HST_HIGH  = 3'h2,
    HST_TRAIL = 3'h3,
    HST_GAP   = 3'h4
  } srwrp_hst_e;
endpackage : srwrp_pkg
